//--- ssfr_pkg.sv
// shared constants and carrier types for the security state fault and filter registers
package ssfr_pkg;

  // security states of the current execution context
  typedef enum logic [1:0] {
    SEC_SECURE    = 2'b00,
    SEC_NONSECURE = 2'b01,
    SEC_ROOT      = 2'b10,
    SEC_REALM     = 2'b11
  } ssfr_state_type;

  // exception levels
  typedef enum logic [1:0] {
    EL_0 = 2'b00,
    EL_1 = 2'b01,
    EL_2 = 2'b10,
    EL_3 = 2'b11
  } ssfr_el_type;

  // register select codes for the system register port (block-local numbering)
  typedef enum logic [2:0] {
    REG_FAULT_ADDR  = 3'b000,
    REG_XLAT_RESULT = 3'b001,
    REG_PB_ID       = 3'b010,
    REG_PB_STATUS   = 3'b011,
    REG_CC_FILTER   = 3'b100
  } ssfr_reg_type;

  // fault address register layout
  localparam int FA_NS_BIT      = 63;
  localparam int FA_NSE_BIT     = 62;
  localparam int FA_HI_MSB      = 51;
  localparam int FA_HI_LSB      = 48;
  localparam int FA_PAGE_MSB    = 47;
  localparam int FA_PAGE_LSB    = 12;

  // translation result layout
  localparam int XR_FAIL_BIT    = 0;
  localparam int XR_NS_BIT      = 9;
  localparam int XR_NSE_BIT     = 11;
  localparam int XR_FST_MSB     = 6;
  localparam int XR_FST_LSB     = 1;

  // profiling buffer id: prohibited flag position
  localparam int PB_PROHIBIT_BIT = 4;

  // profiling buffer status layout
  localparam int PBS_EC_MSB     = 31;
  localparam int PBS_EC_LSB     = 26;
  localparam int PBS_FSC_MSB    = 5;
  localparam int PBS_FSC_LSB    = 0;

  // cycle counter filter layout
  localparam int CF_P_BIT       = 31;
  localparam int CF_U_BIT       = 30;
  localparam int CF_NSH_BIT     = 27;
  localparam int CF_RLK_BIT     = 22;
  localparam int CF_RLU_BIT     = 21;
  localparam int CF_RLH_BIT     = 20;

  // fault codes, event class and buffer owner control value
  localparam logic [5:0] FSC_GPF_WALK_LM1 = 6'h23;
  localparam logic [3:0] FSC_GPF_WALK_PFX = 4'h9;
  localparam logic [5:0] FSC_GPF_NOWALK   = 6'h28;
  localparam logic [5:0] EC_GPC_FAULT     = 6'h1E;
  localparam logic [1:0] EL2_BUFFER_OWNER_CTRL_OWNED_EL1   = 2'h0;

  localparam logic [63:0] REG_RESET = 64'h0;

  // granule check fault event
  typedef struct packed {
    logic [51:0]    pa;
    ssfr_state_type space;
  } ssfr_gpc_fault_type;

  // system register access request
  typedef struct packed {
    logic           write;
    ssfr_reg_type   sel;
    logic [63:0]    wdata;
  } ssfr_sysreg_req_type;

  // translation outcome event
  typedef struct packed {
    logic           fail;
    logic           gpf;
    logic           walk;
    logic           levelM1;
    logic [1:0]     level;
    logic           space_extension_bit;
    logic           ns;
    logic [5:0]     otherFst;
  } ssfr_xlat_evt_type;

endpackage

//--- ssfr_owner_decode.sv
// profiling buffer prohibited-flag decode from owner, state and level
`timescale 1ns/10ps
module ssfr_owner_decode (
  // configuration
  input  wire logic                      hasEl3,
  input  wire logic                      hasEl2,
  input  wire logic                      secEl2Present,
  input  wire logic                      secEl2Enabled,
  input  wire logic [1:0]                el2BufferOwnerCtrl,
  input  wire ssfr_pkg::ssfr_state_type  owner,
  // current context
  input  wire ssfr_pkg::ssfr_state_type  curState,
  input  wire ssfr_pkg::ssfr_el_type     curEl,
  // result
  output logic                           prohibited
);
  import ssfr_pkg::*;

  wire ctrlEl1  = (el2BufferOwnerCtrl == EL2_BUFFER_OWNER_CTRL_OWNED_EL1);
  wire isEl1    = (curEl == EL_1);
  wire isEl2    = (curEl == EL_2);
  wire isEl12   = isEl1 | isEl2;
  wire inSec    = (curState == SEC_SECURE);
  wire inNs     = (curState == SEC_NONSECURE);
  wire inRealm  = (curState == SEC_REALM);

  wire ownSec   = hasEl3 & (owner == SEC_SECURE) & (
                    ((inNs | inRealm) & isEl12) |
                    (inSec & isEl1 & secEl2Present & secEl2Enabled & ctrlEl1));
  wire ownNs    = hasEl3 & (owner == SEC_NONSECURE) & (
                    (inSec & isEl1) |
                    (inSec & isEl2 & secEl2Present) |
                    (inRealm & isEl12) |
                    (inNs & isEl1 & hasEl2 & ctrlEl1));
  wire ownRealm = hasEl3 & (owner == SEC_REALM) & (
                    ((inNs | inSec) & isEl12) |
                    (inRealm & isEl1 & ctrlEl1));
  wire noEl3    = ~hasEl3 & hasEl2 & ctrlEl1 & isEl1;

  assign prohibited = ownSec | ownNs | ownRealm | noEl3;

endmodule // ssfr_owner_decode

//--- ssfr_regs.sv
// security state fault address, translation result, profiling and cycle filter registers
`timescale 1ns/10ps
module ssfr_regs #(
  parameter int  PA_WIDTH       = 48,
  parameter bit  HAS_LARGE_PA   = 1'b1,
  parameter bit  HAS_LPA2       = 1'b1,
  parameter bit  HAS_REALM      = 1'b1
) (
  // clock and warm reset
  input  wire logic                          mclk,
  input  wire logic                          sys_rst,
  // system register access
  input  wire logic                          regValid,
  input  wire ssfr_pkg::ssfr_sysreg_req_type regReq,
  input  wire ssfr_pkg::ssfr_state_type      curState,
  input  wire ssfr_pkg::ssfr_el_type         curEl,
  output logic [63:0]                        regRdata,
  output logic                               regUndef,
  // configuration
  input  wire logic                          hasEl3,
  input  wire logic                          hasEl2,
  input  wire logic                          secEl2Present,
  input  wire logic                          secEl2Enabled,
  input  wire logic [1:0]                    el2BufferOwnerCtrl,
  input  wire ssfr_pkg::ssfr_state_type      bufferOwner,
  // hardware events
  input  wire logic                          gpcFaultValid,
  input  wire ssfr_pkg::ssfr_gpc_fault_type  gpcFault,
  input  wire logic                          xlatValid,
  input  wire ssfr_pkg::ssfr_el_type         xlatRegimeEl,
  input  wire ssfr_pkg::ssfr_state_type      xlatRegimeState,
  input  wire logic                          xlatRealmEl10S1,
  input  wire ssfr_pkg::ssfr_xlat_evt_type   xlatEvt,
  input  wire logic                          pbAbortValid,
  input  wire ssfr_pkg::ssfr_xlat_evt_type   pbAbort,
  // cycle counter gating
  output logic                               cycleCountEn
);
  import ssfr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [63:0] faultAddr_q, faultAddr_d;
  logic [63:0] xlatResult_q, xlatResult_d;
  logic [63:0] pbStatus_q, pbStatus_d;
  logic [63:0] ccFilter_q, ccFilter_d;

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  wire selFa     = (regReq.sel == REG_FAULT_ADDR);
  wire selXr     = (regReq.sel == REG_XLAT_RESULT);
  wire selPbId   = (regReq.sel == REG_PB_ID);
  wire selPbs    = (regReq.sel == REG_PB_STATUS);
  wire selCf     = (regReq.sel == REG_CC_FILTER);
  wire knownSel  = selFa | selXr | selPbId | selPbs | selCf;
  // fault address only exists with realm support and only from the top level
  wire faDenied  = selFa & (~HAS_REALM | (curEl != EL_3));
  wire accOk     = regValid & knownSel & ~faDenied;
  wire wrFa      = accOk & regReq.write & selFa;
  wire wrXr      = accOk & regReq.write & selXr;
  wire wrPbs     = accOk & regReq.write & selPbs;
  wire wrCf      = accOk & regReq.write & selCf;

  ////////////////////////////////////////////////////////////////////////////
  // fault address masking

  // implemented physical address bits within the 52-bit field
  localparam int PA_TOP = HAS_LARGE_PA ? ((PA_WIDTH > 52) ? 52 : PA_WIDTH)
                                       : ((PA_WIDTH > 48) ? 48 : PA_WIDTH);
  logic [63:0] faMask;
  genvar gi;
  generate
    for (gi = 0; gi < 64; gi++) begin : g_famask
      if (gi == FA_NS_BIT || gi == FA_NSE_BIT) begin : g_sp
        assign faMask[gi] = 1'b1;
      end else if (gi >= FA_PAGE_LSB && gi < PA_TOP) begin : g_pa
        assign faMask[gi] = 1'b1;
      end else begin : g_z
        assign faMask[gi] = 1'b0;
      end
    end
  endgenerate

  // the fault source already supplies the descriptor address for walk faults
  logic [63:0] faCapture;
  assign faCapture = {gpcFault.space[0], gpcFault.space[1], 10'h000,
                      gpcFault.pa[51:12], 12'h000} & faMask;

  // hardware capture wins over a same-cycle software write
  assign faultAddr_d = gpcFaultValid ? faCapture :
                       wrFa          ? (regReq.wdata & faMask) : faultAddr_q;

  ////////////////////////////////////////////////////////////////////////////
  // translation result

  // walk-level granule fault code; level -1 only with 52-bit translation
  function automatic logic [5:0] gpfCode(input ssfr_xlat_evt_type e,
                                         input logic             lpa2);
    logic [5:0] c;
    c = e.otherFst;
    if (e.gpf && e.walk && e.levelM1 && lpa2) begin
      c = FSC_GPF_WALK_LM1;
    end else if (e.gpf && e.walk && !e.levelM1) begin
      c = {FSC_GPF_WALK_PFX, e.level};
    end
    return c;
  endfunction

  wire xrTopRegime = (xlatRegimeEl == EL_3);
  // unknown cases are given zero
  wire xrNseOk = xrTopRegime;
  wire xrNsOk  = (xrTopRegime | (xlatRegimeState == SEC_SECURE) |
                  (xlatRegimeState == SEC_REALM)) & ~xlatRealmEl10S1;

  logic [63:0] xrOk, xrFail;
  always_comb begin
    xrOk = 64'h0;
    xrOk[XR_NSE_BIT] = xrNseOk & xlatEvt.space_extension_bit;
    xrOk[XR_NS_BIT]  = xrNsOk & xlatEvt.ns;
    xrFail = 64'h0;
    xrFail[XR_FAIL_BIT] = 1'b1;
    xrFail[XR_FST_MSB:XR_FST_LSB] = gpfCode(xlatEvt, HAS_LPA2);
  end

  assign xlatResult_d = xlatValid ? (xlatEvt.fail ? xrFail : xrOk) :
                        wrXr      ? regReq.wdata : xlatResult_q;

  ////////////////////////////////////////////////////////////////////////////
  // profiling buffer status

  logic [63:0] pbsCapture;
  always_comb begin
    pbsCapture = pbStatus_q;
    // granule faults outside a walk take their own class
    pbsCapture[PBS_EC_MSB:PBS_EC_LSB] = (pbAbort.gpf && !pbAbort.walk) ?
                                         EC_GPC_FAULT : pbStatus_q[PBS_EC_MSB:PBS_EC_LSB];
    pbsCapture[PBS_FSC_MSB:PBS_FSC_LSB] = (pbAbort.gpf && !pbAbort.walk) ?
                                           FSC_GPF_NOWALK : gpfCode(pbAbort, HAS_LPA2);
  end

  assign pbStatus_d = pbAbortValid ? pbsCapture :
                      wrPbs        ? regReq.wdata : pbStatus_q;

  ////////////////////////////////////////////////////////////////////////////
  // profiling buffer id

  logic pbProhibited;
  ssfr_owner_decode u_owner (
    .hasEl3             (hasEl3),
    .hasEl2             (hasEl2),
    .secEl2Present      (secEl2Present),
    .secEl2Enabled      (secEl2Enabled),
    .el2BufferOwnerCtrl (el2BufferOwnerCtrl),
    .owner              (bufferOwner),
    .curState           (curState),
    .curEl              (curEl),
    .prohibited         (pbProhibited)
  );

  logic [63:0] pbIdView;
  always_comb begin
    pbIdView = 64'h0;
    pbIdView[PB_PROHIBIT_BIT] = pbProhibited;
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle counter filter

  logic [63:0] cfMask;
  always_comb begin
    cfMask = 64'hFFFFFFFF_FFFFFFFF;
    if (!HAS_REALM) begin
      cfMask[CF_RLK_BIT] = 1'b0;
      cfMask[CF_RLU_BIT] = 1'b0;
      cfMask[CF_RLH_BIT] = 1'b0;
    end
  end

  assign ccFilter_d = wrCf ? (regReq.wdata & cfMask) : ccFilter_q;

  wire cfP   = ccFilter_q[CF_P_BIT];
  wire cfU   = ccFilter_q[CF_U_BIT];
  wire cfNsh = ccFilter_q[CF_NSH_BIT];
  wire cfRlk = ccFilter_q[CF_RLK_BIT];
  wire cfRlu = ccFilter_q[CF_RLU_BIT];
  wire cfRlh = ccFilter_q[CF_RLH_BIT];

  // only the realm gating lives here; other states defer to the base filter
  wire realmCount = (curEl == EL_1) ? (cfRlk == cfP) :
                    (curEl == EL_0) ? (cfRlu == cfU) :
                    (curEl == EL_2) ? (cfRlh != cfNsh) : 1'b0;
  assign cycleCountEn = (curState == SEC_REALM) ? (HAS_REALM & realmCount) : 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // read path

  wire [63:0] rdMux = selFa   ? faultAddr_q  :
                      selXr   ? xlatResult_q :
                      selPbId ? pbIdView     :
                      selPbs  ? pbStatus_q   :
                      selCf   ? ccFilter_q   : 64'h0;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // unknown-reset fields are given zero for determinism
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      faultAddr_q  <= REG_RESET;
      xlatResult_q <= REG_RESET;
      pbStatus_q   <= REG_RESET;
      ccFilter_q   <= REG_RESET;
    end else begin
      faultAddr_q  <= faultAddr_d;
      xlatResult_q <= xlatResult_d;
      pbStatus_q   <= pbStatus_d;
      ccFilter_q   <= ccFilter_d;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= 64'h0;
      regUndef <= 1'b0;
    end else begin
      regRdata <= (accOk & ~regReq.write) ? rdMux : 64'h0;
      regUndef <= regValid & (~knownSel | faDenied);
    end
  end

endmodule // ssfr_regs

//--- ssfr_regs_checker.sv
// concurrent checks on the security state fault and filter register ports
`timescale 1ns/10ps
module ssfr_regs_checker
  import ssfr_pkg::*;
#(
  parameter int PA_WIDTH     = 48,
  parameter bit HAS_LARGE_PA = 1'b1,
  parameter bit HAS_LPA2     = 1'b1,
  parameter bit HAS_REALM    = 1'b1
) (
  // clock and reset
  input wire logic                          mclk,
  input wire logic                          sys_rst,
  // register port
  input wire logic                          regValid,
  input wire ssfr_pkg::ssfr_sysreg_req_type regReq,
  input wire ssfr_pkg::ssfr_state_type      curState,
  input wire ssfr_pkg::ssfr_el_type         curEl,
  input wire logic [63:0]                   regRdata,
  input wire logic                          regUndef,
  // events and gating
  input wire logic                          gpcFaultValid,
  input wire ssfr_pkg::ssfr_gpc_fault_type  gpcFault,
  input wire logic                          xlatValid,
  input wire ssfr_pkg::ssfr_xlat_evt_type   xlatEvt,
  input wire logic                          pbAbortValid,
  input wire ssfr_pkg::ssfr_xlat_evt_type   pbAbort,
  input wire logic                          cycleCountEn
);
  ////////////////////////////////////////////////////////////////////////////////
  // shadow of the filter register, so gating can be judged from the ports alone
  logic [63:0] ccShadow_q;
  wire rdFa = regValid && !regReq.write && regReq.sel == REG_FAULT_ADDR;
  wire rdXr = regValid && !regReq.write && regReq.sel == REG_XLAT_RESULT;
  wire rdPs = regValid && !regReq.write && regReq.sel == REG_PB_STATUS;
  wire inRealm = curState == SEC_REALM;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) ccShadow_q <= REG_RESET;
    else if (regValid && regReq.write && regReq.sel == REG_CC_FILTER) ccShadow_q <= regReq.wdata;
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_undef_low_el: assert property (rdFa && curEl != EL_3 |=> regUndef && regRdata == 64'h0)
    else $error("fault address reachable below the highest level");
  a_fault_space: assert property (gpcFaultValid ##1 (rdFa && curEl == EL_3 && !gpcFaultValid)
    |=> regRdata[63:62] == {$past(gpcFault.space[0], 2), $past(gpcFault.space[1], 2)})
    else $error("fault space bits wrong");
  a_fault_page: assert property (gpcFaultValid ##1 (rdFa && curEl == EL_3 && !gpcFaultValid)
    |=> regRdata[47:12] == $past(gpcFault.pa[47:12], 2))
    else $error("fault page address wrong");
  a_fault_res_zero: assert property (rdFa && curEl == EL_3
    |=> regRdata[61:52] == 10'h0 && regRdata[11:0] == 12'h0)
    else $error("reserved fault address bits not zero");
  a_xlat_level: assert property (xlatValid && xlatEvt.fail && xlatEvt.gpf && xlatEvt.walk
    && !xlatEvt.levelM1 ##1 (rdXr && !xlatValid)
    |=> regRdata[6:0] == {FSC_GPF_WALK_PFX, $past(xlatEvt.level, 2), 1'b1})
    else $error("walk level fault code wrong");
  a_xlat_minus_one: assert property (xlatValid && xlatEvt.fail && xlatEvt.gpf && xlatEvt.walk
    && xlatEvt.levelM1 ##1 (rdXr && !xlatValid)
    |=> regRdata[6:1] == (HAS_LPA2 ? FSC_GPF_WALK_LM1 : $past(xlatEvt.otherFst, 2)))
    else $error("level minus one fault code wrong");
  a_pbs_nowalk: assert property (pbAbortValid && pbAbort.gpf && !pbAbort.walk
    ##1 (rdPs && !pbAbortValid)
    |=> regRdata[31:26] == EC_GPC_FAULT && regRdata[5:0] == FSC_GPF_NOWALK)
    else $error("buffer status class or code wrong");
  a_cc_realm_el1: assert property (inRealm && curEl == EL_1
    |-> cycleCountEn == (ccShadow_q[CF_RLK_BIT] == ccShadow_q[CF_P_BIT]))
    else $error("realm EL1 gating wrong");
  a_cc_realm_el0: assert property (inRealm && curEl == EL_0
    |-> cycleCountEn == (ccShadow_q[CF_RLU_BIT] == ccShadow_q[CF_U_BIT]))
    else $error("realm EL0 gating wrong");
  a_cc_realm_el2: assert property (inRealm && curEl == EL_2
    |-> cycleCountEn == (ccShadow_q[CF_RLH_BIT] != ccShadow_q[CF_NSH_BIT]))
    else $error("realm EL2 gating wrong");
endmodule // ssfr_regs_checker

bind ssfr_regs ssfr_regs_checker #(.PA_WIDTH(PA_WIDTH), .HAS_LARGE_PA(HAS_LARGE_PA),
  .HAS_LPA2(HAS_LPA2), .HAS_REALM(HAS_REALM)) i_checker (.mclk(mclk), .sys_rst(sys_rst),
  .regValid(regValid), .regReq(regReq), .curState(curState), .curEl(curEl),
  .regRdata(regRdata), .regUndef(regUndef), .gpcFaultValid(gpcFaultValid),
  .gpcFault(gpcFault), .xlatValid(xlatValid), .xlatEvt(xlatEvt),
  .pbAbortValid(pbAbortValid), .pbAbort(pbAbort), .cycleCountEn(cycleCountEn));

//--- security_state_fault_and_filter_regs_tb_top.sv
// self-checking bench for the security state fault and filter registers
`timescale 1ns/10ps
module security_state_fault_and_filter_regs_tb_top;
  import ssfr_pkg::*;
  logic                mclk, sysRst, regValid, regUndef, rdUndef, cycleCountEn;
  logic                hasEl3, hasEl2, secEl2Present, secEl2Enabled, xlatRealmEl10S1;
  logic                gpcFaultValid, xlatValid, pbAbortValid;
  logic [1:0]          el2BufferOwnerCtrl;
  logic [63:0]         regRdata, rdData, expVal;
  ssfr_sysreg_req_type regReq;
  ssfr_state_type      curState, bufferOwner, xlatRegimeState;
  ssfr_el_type         curEl, xlatRegimeEl;
  ssfr_gpc_fault_type  gpcFault;
  ssfr_xlat_evt_type   xlatEvt, pbAbort;
  int                  failures, testsRun;

  // wide address so the upper fault bits are stored
  ssfr_regs #(.PA_WIDTH(52), .HAS_LARGE_PA(1'b1), .HAS_LPA2(1'b1), .HAS_REALM(1'b1)) i_dut (
    .mclk(mclk), .sys_rst(sysRst), .regValid(regValid), .regReq(regReq),
    .curState(curState), .curEl(curEl), .regRdata(regRdata), .regUndef(regUndef),
    .hasEl3(hasEl3), .hasEl2(hasEl2), .secEl2Present(secEl2Present),
    .secEl2Enabled(secEl2Enabled), .el2BufferOwnerCtrl(el2BufferOwnerCtrl),
    .bufferOwner(bufferOwner), .gpcFaultValid(gpcFaultValid), .gpcFault(gpcFault),
    .xlatValid(xlatValid), .xlatRegimeEl(xlatRegimeEl), .xlatRegimeState(xlatRegimeState),
    .xlatRealmEl10S1(xlatRealmEl10S1), .xlatEvt(xlatEvt), .pbAbortValid(pbAbortValid),
    .pbAbort(pbAbort), .cycleCountEn(cycleCountEn));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    testsRun++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one access, answer taken one cycle later; an idle cycle keeps strobes apart
  task automatic acc(input logic wr, input ssfr_reg_type sel, input logic [63:0] wd);
    regValid = 1'b1;
    regReq   = '{write: wr, sel: sel, wdata: wd};
    @(posedge mclk);
    #1;
    regValid = 1'b0;
    rdData   = regRdata;
    rdUndef  = regUndef;
    @(posedge mclk);
    #1;
  endtask

  task automatic evt(input logic pb, input ssfr_xlat_evt_type e, input ssfr_el_type el,
                     input ssfr_state_type st);
    xlatEvt         = e;
    pbAbort         = e;
    xlatRegimeEl    = el;
    xlatRegimeState = st;
    if (pb) pbAbortValid = 1'b1;
    else xlatValid = 1'b1;
    @(posedge mclk);
    #1;
    pbAbortValid = 1'b0;
    xlatValid    = 1'b0;
    acc(1'b0, pb ? REG_PB_STATUS : REG_XLAT_RESULT, 64'h0);
  endtask

  task automatic pbCase(input logic e3, e2, sp, se, input logic [1:0] ctl,
                        input ssfr_state_type own, st, input ssfr_el_type el, input logic exp);
    hasEl3             = e3;
    hasEl2             = e2;
    secEl2Present      = sp;
    secEl2Enabled      = se;
    el2BufferOwnerCtrl = ctl;
    bufferOwner        = own;
    curState           = st;
    curEl              = el;
    acc(1'b0, REG_PB_ID, 64'h0);
    chk(64'(rdData[PB_PROHIBIT_BIT]), 64'(exp));
  endtask

  task automatic report_and_stop;
    $display("checks made %0d, mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // whole run is under 200 cycles
  initial begin
    #100000;
    failures++;
    report_and_stop();
  end

  initial begin
    failures = 0; testsRun = 0; sysRst = 1'b1; regValid = 1'b0; regReq = '0;
    curState = SEC_ROOT; curEl = EL_3; hasEl3 = 1'b1; hasEl2 = 1'b1; secEl2Present = 1'b1;
    secEl2Enabled = 1'b1; el2BufferOwnerCtrl = 2'h0; bufferOwner = SEC_SECURE;
    gpcFaultValid = 1'b0; gpcFault = '0; xlatValid = 1'b0; pbAbortValid = 1'b0;
    xlatRegimeEl = EL_1; xlatRegimeState = SEC_NONSECURE; xlatRealmEl10S1 = 1'b0;
    xlatEvt = '0; pbAbort = '0;
    repeat (6) @(posedge mclk);
    #1 sysRst = 1'b0;
    acc(1'b0, REG_CC_FILTER, 64'h0); chk(rdData, REG_RESET);
    $display("test reset values done");
    for (int s = 0; s < 4; s++) begin
      gpcFault      = '{pa: {4'(s + 8), 48'hBCDE_F012_3456}, space: ssfr_state_type'(s)};
      gpcFaultValid = 1'b1;
      @(posedge mclk);
      #1 gpcFaultValid = 1'b0;
      acc(1'b0, REG_FAULT_ADDR, 64'h0);
      expVal = {s[0], s[1], 10'h0, 4'(s + 8), 36'hB_CDEF_0123, 12'h0};
      chk(rdData, expVal);
    end
    curEl = EL_2;
    acc(1'b1, REG_FAULT_ADDR, 64'hFFFF_FFFF_FFFF_FFFF); chk(64'(rdUndef), 64'h1);
    acc(1'b0, REG_FAULT_ADDR, 64'h0); chk(rdData, 64'h0);
    curEl = EL_3;
    acc(1'b0, REG_FAULT_ADDR, 64'h0); chk(rdData, expVal);
    acc(1'b0, ssfr_reg_type'(3'h7), 64'h0); chk(64'(rdUndef), 64'h1);
    $display("test fault address done");
    for (int l = 0; l < 4; l++) begin
      evt(1'b0, '{1'b1, 1'b1, 1'b1, 1'b0, 2'(l), 1'b0, 1'b0, 6'h15}, EL_1, SEC_NONSECURE);
      chk(rdData & 64'h7F, {57'h0, 4'h9, 2'(l), 1'b1});
    end
    evt(1'b0, '{1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 1'b0, 1'b0, 6'h15}, EL_1, SEC_NONSECURE);
    chk(rdData & 64'h7F, 64'h47);
    evt(1'b0, '{1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 1'b1, 6'h0}, EL_3, SEC_ROOT);
    chk(rdData & 64'hA01, 64'hA00);
    evt(1'b0, '{1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1, 6'h0}, EL_2, SEC_REALM);
    chk(rdData & 64'h201, 64'h200);
    // realm EL1&0 stage 1 result has no reported nonsecure bit; given zero
    xlatRealmEl10S1 = 1'b1;
    evt(1'b0, '{1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 1'b1, 6'h0}, EL_1, SEC_REALM);
    chk(rdData & 64'hA01, 64'h000);
    xlatRealmEl10S1 = 1'b0;
    $display("test translation result done");
    evt(1'b1, '{1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 1'b0, 1'b0, 6'h15}, EL_1, SEC_NONSECURE);
    chk(rdData & 64'h3F, 64'h23);
    evt(1'b1, '{1'b1, 1'b1, 1'b1, 1'b0, 2'h2, 1'b0, 1'b0, 6'h15}, EL_1, SEC_NONSECURE);
    chk(rdData & 64'h3F, 64'h26);
    evt(1'b1, '{1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 6'h15}, EL_1, SEC_NONSECURE);
    chk(rdData & 64'hFC00_003F, 64'h7800_0028);
    $display("test buffer status done");
    acc(1'b1, REG_PB_ID, 64'hFFFF_FFFF_FFFF_FFFF);
    pbCase(1, 1, 1, 1, 2'h0, SEC_SECURE, SEC_NONSECURE, EL_1, 1'b1);
    pbCase(1, 1, 1, 1, 2'h0, SEC_SECURE, SEC_REALM, EL_2, 1'b1);
    pbCase(1, 1, 1, 1, 2'h0, SEC_SECURE, SEC_SECURE, EL_1, 1'b1);
    pbCase(1, 1, 1, 1, 2'h1, SEC_SECURE, SEC_SECURE, EL_1, 1'b0);
    pbCase(1, 1, 1, 1, 2'h1, SEC_NONSECURE, SEC_SECURE, EL_2, 1'b1);
    pbCase(1, 1, 1, 1, 2'h0, SEC_NONSECURE, SEC_NONSECURE, EL_1, 1'b1);
    pbCase(1, 1, 1, 1, 2'h0, SEC_NONSECURE, SEC_NONSECURE, EL_2, 1'b0);
    pbCase(1, 1, 1, 1, 2'h1, SEC_REALM, SEC_SECURE, EL_1, 1'b1);
    pbCase(1, 1, 1, 1, 2'h0, SEC_REALM, SEC_REALM, EL_1, 1'b1);
    pbCase(1, 1, 1, 1, 2'h2, SEC_REALM, SEC_REALM, EL_1, 1'b0);
    pbCase(0, 1, 0, 0, 2'h0, SEC_NONSECURE, SEC_NONSECURE, EL_1, 1'b1);
    pbCase(0, 1, 0, 0, 2'h1, SEC_NONSECURE, SEC_NONSECURE, EL_1, 1'b0);
    $display("test buffer prohibit done");
    curState = SEC_REALM;
    // P and NONSECURE_EL2_FILTER set, U clear: each realm filter bit flips its own level only
    for (int i = 0; i < 8; i++) begin
      expVal = 64'h8800_0000 | (64'(i) << 20);
      acc(1'b1, REG_CC_FILTER, expVal);
      acc(1'b0, REG_CC_FILTER, 64'h0); chk(rdData, expVal);
      curEl = EL_1;
      #1 chk(64'(cycleCountEn), 64'(i[2]));
      @(posedge mclk);
      #1 curEl = EL_0;
      #1 chk(64'(cycleCountEn), 64'(!i[1]));
      @(posedge mclk);
      #1 curEl = EL_2;
      #1 chk(64'(cycleCountEn), 64'(!i[0]));
      @(posedge mclk);
      #1;
    end
    // outside realm the base filter alone decides
    curState = SEC_NONSECURE;
    #1 chk(64'(cycleCountEn), 64'h1);
    @(posedge mclk);
    #1 sysRst = 1'b1;
    @(posedge mclk);
    #1 sysRst = 1'b0;
    acc(1'b0, REG_CC_FILTER, 64'h0); chk(rdData, REG_RESET);
    $display("test cycle filter done");
    report_and_stop();
  end
endmodule // security_state_fault_and_filter_regs_tb_top
